// ===== lftp_pkg.sv
// shared constants, types and check functions for the lf transponder link
package lftp_pkg;

	localparam int CLK_KHZ          = 10000;
	localparam int RESET_DELAY_US   = 100;
	localparam int RESET_DELAY_CYC  = RESET_DELAY_US * CLK_KHZ / 1000;
	localparam int PAUSE_US         = 2000;
	localparam int PAUSE_CYC        = PAUSE_US * CLK_KHZ / 1000;
	localparam int ERR_FREQ_HZ      = 1000;
	localparam int ERR_HALF_CYC     = CLK_KHZ * 1000 / (2 * ERR_FREQ_HZ);
	localparam logic [4:0] ERR_HALF_LAST = 5'h0f;
	localparam logic [3:0] UP_HALF_LAST  = 4'hf;
	localparam logic [3:0] RX_BITS       = 4'h8;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [2:0] TX_UID_FIRST  = 3'h1;
	localparam logic [2:0] TX_CRC_IDX    = 3'h5;
	localparam logic [2:0] TX_BYTES      = 3'h6;
	localparam logic [9:0] PLEN_MAX      = 10'h3ff;

	localparam logic [1:0] DLP_BINARY = 2'h0;
	localparam logic [1:0] DLP_QUAD   = 2'h1;
	localparam logic [1:0] DLP_DPS    = 2'h2;

	localparam logic [3:0] CMD_READ_UID = 4'h0;
	localparam logic [7:0] RESP_HEADER  = 8'hfe;
	localparam logic [3:0] CRC4_POLY    = 4'h3;
	localparam logic [3:0] CRC4_INIT    = 4'h0;
	localparam logic [7:0] CRC8_POLY    = 8'h07;
	localparam logic [7:0] CRC8_INIT    = 8'h00;

	localparam logic [3:0] ERR_NONE  = 4'h0;
	localparam logic [3:0] ERR_CHECK = 4'h1;
	localparam logic [3:0] ERR_CMD   = 4'h2;

	typedef enum {st_wait, st_check, st_app, st_setup, st_header,
		st_rx, st_pause, st_tx, st_err} lftp_state_t;

	typedef struct packed {
		logic       detection_header_enable;
		logic [1:0] downlink_protocol_select;
		logic       uplink_biphase;
		logic [7:0] pulse_threshold;
	} lftp_cfg_t;

	typedef struct packed {
		logic field_ack;
		logic clk_reconfig;
		logic low_power;
		logic boot_vectors;
		logic wdt_arm;
		logic link_init;
	} lftp_setup_t;

	function automatic logic [3:0] lftp_crc4(input logic [3:0] d,
		input logic [3:0] poly, input logic [3:0] init);
		logic [3:0] c;
		c = init;
		for (int i = 3; i >= 0; i--) begin
			c = (c[3] ^ d[i]) ? ((c << 1) ^ poly) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [7:0] lftp_crc8(input logic [7:0] d,
		input logic [7:0] poly, input logic [7:0] init);
		logic [7:0] c;
		c = init;
		for (int i = 7; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ((c << 1) ^ poly) : (c << 1);
		end
		return c;
	endfunction

endpackage

// ===== lftp_frontend.sv
// transponder-side lf link front end: start-up, downlink, uplink, frames
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module lftp_frontend
	import lftp_pkg::*;
#(
	parameter int         PAUSE_CYCLES    = PAUSE_CYC,
	parameter int         ERR_HALF_CYCLES = ERR_HALF_CYC,
	parameter logic [3:0] CHK_POLY        = CRC4_POLY,
	parameter logic [3:0] CHK_INIT        = CRC4_INIT,
	parameter logic [7:0] PAY_POLY        = CRC8_POLY,
	parameter logic [7:0] PAY_INIT        = CRC8_INIT
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        field_on,
	input  wire logic        field_carrier,
	input  wire lftp_cfg_t   cfg,
	input  wire logic [31:0] unique_serial_id,
	output lftp_setup_t      setup,
	output logic             app_mode,
	output logic             uplink_damp,
	output logic [7:0]       last_status
);

	lftp_state_t state;
	lftp_state_t next_state;
	logic        field_m;
	logic        field_s;
	logic        field_d;
	logic        car_m;
	logic        car_s;
	logic        car_d;
	logic        car_tick;
	logic        field_rise;
	logic        field_fall;
	logic [15:0] tmr;
	logic [15:0] tmr_lim;
	logic        tmr_end;
	logic [4:0]  err_n;
	logic        err_lvl;
	logic [9:0]  plen;
	logic [9:0]  thr1;
	logic [9:0]  thr2;
	logic [9:0]  thr3;
	logic        pulse_end;
	logic        pulse_live;
	logic [7:0]  rx_sh;
	logic [3:0]  rx_n;
	logic        rx_full;
	logic        dps_gap;
	logic [3:0]  next_code;
	logic [2:0]  tx_idx;
	logic [7:0]  tx_crc;
	logic [7:0]  push_byte;
	logic        push;
	logic [7:0]  fifo_mem [2];
	logic        wp;
	logic        rp;
	logic [1:0]  cnt;
	logic        in_ready;
	logic        out_valid;
	logic        out_ready;
	logic [7:0]  ser_sh;
	logic [3:0]  ser_n;
	logic        ser_load;
	logic        up_run;
	logic        up_bit;
	logic        next_bit;
	logic        half;
	logic [3:0]  ccnt;
	logic        bp_lvl;
	logic        bit_end;
	logic        next_damp;
	logic        dps_mode;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edges
	always_ff @(posedge core_clk) begin
		if (reset) begin
			field_m <= 1'h0;
			field_s <= 1'h0;
			field_d <= 1'h0;
			car_m   <= 1'h0;
			car_s   <= 1'h0;
			car_d   <= 1'h0;
		end else begin
			field_m <= field_on;
			field_s <= field_m;
			field_d <= field_s;
			car_m   <= field_carrier;
			car_s   <= car_m;
			car_d   <= car_s;
		end
	end

	assign car_tick   = car_s & ~car_d;
	assign field_rise = field_s & ~field_d;
	assign field_fall = ~field_s & field_d;
	assign dps_mode   = cfg.downlink_protocol_select == DLP_DPS;

	////////////////////////////////////////////////////////////////////////
	// sequence control
	always_comb begin
		case (state)
			st_wait:  tmr_lim = 16'(RESET_DELAY_CYC - 1);
			st_pause: tmr_lim = 16'(PAUSE_CYCLES - 1);
			st_err:   tmr_lim = 16'(ERR_HALF_CYCLES - 1);
			default:  tmr_lim = 16'h0000;
		endcase
	end

	assign tmr_end = tmr == tmr_lim;

	always_comb begin
		next_state = state;
		case (state)
			st_wait: if (tmr_end) next_state = st_check;
			// enhanced-mode step has no place in this sequence
			st_check: next_state = field_s ? st_setup : st_app;
			st_app: next_state = st_app;
			st_setup: begin
				if (cfg.detection_header_enable) begin
					next_state = st_header;
				end else begin
					next_state = st_rx;
				end
			end
			st_header: if (field_fall && uplink_damp) next_state = st_rx;
			st_rx: if (rx_full) next_state = st_pause;
			st_pause: begin
				if (tmr_end) begin
					next_state = (last_status[3:0] == ERR_NONE) ? st_tx : st_err;
				end
			end
			st_tx: begin
				if (tx_idx == TX_BYTES && !out_valid && ser_n == 4'h0) begin
					next_state = st_rx;
				end
			end
			st_err: if (tmr_end && err_n == ERR_HALF_LAST) next_state = st_rx;
			default: next_state = st_wait;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= st_wait;
			tmr   <= 16'h0000;
		end else begin
			state <= next_state;
			tmr   <= (next_state != state || tmr_end) ? 16'h0000 : tmr + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || state != st_err) begin
			err_n   <= 5'h00;
			err_lvl <= 1'h1;
		end else if (tmr_end) begin
			err_n   <= err_n + 5'h01;
			err_lvl <= ~err_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start-up outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			setup    <= '0;
			app_mode <= 1'h0;
		end else begin
			if (state == st_setup) setup <= '1;
			if (state == st_app) app_mode <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// downlink pulse measurement
	assign thr1 = {2'h0, cfg.pulse_threshold};
	assign thr2 = {1'h0, cfg.pulse_threshold, 1'h0};
	assign thr3 = thr1 + thr2;
	assign pulse_end = field_fall && state == st_rx && !dps_mode && !rx_full &&
		pulse_live;

	always_ff @(posedge core_clk) begin
		if (reset || field_rise) begin
			plen <= 10'h000;
		end else if (field_s && car_tick && plen != PLEN_MAX) begin
			plen <= plen + 10'h001;
		end
	end

	// steady field before a frame is no pulse: only burst begun in receive
	always_ff @(posedge core_clk) begin
		if (reset || state != st_rx) begin
			pulse_live <= 1'h0;
		end else if (field_rise) begin
			pulse_live <= 1'h1;
		end else if (field_fall) begin
			pulse_live <= 1'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || state != st_rx) begin
			dps_gap <= 1'h0;
		end else if (bit_end) begin
			dps_gap <= 1'h0;
		end else if (field_fall && uplink_damp) begin
			dps_gap <= 1'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || state != st_rx) begin
			rx_sh <= 8'h00;
			rx_n  <= 4'h0;
		end else if (pulse_end &&
			cfg.downlink_protocol_select == DLP_QUAD) begin
			rx_n <= rx_n + 4'h2;
			if (plen < thr1) rx_sh <= {rx_sh[5:0], 2'h0};
			else if (plen < thr2) rx_sh <= {rx_sh[5:0], 2'h1};
			else if (plen < thr3) rx_sh <= {rx_sh[5:0], 2'h2};
			else rx_sh <= {rx_sh[5:0], 2'h3};
		end else if (pulse_end) begin
			rx_n  <= rx_n + 4'h1;
			rx_sh <= {rx_sh[6:0], plen > thr1};
		end else if (dps_mode && bit_end && !rx_full) begin
			rx_n  <= rx_n + 4'h1;
			rx_sh <= {rx_sh[6:0], dps_gap};
		end
	end

	assign rx_full = rx_n == RX_BITS;

	always_comb begin
		if (rx_sh[3:0] != lftp_crc4(rx_sh[7:4], CHK_POLY, CHK_INIT)) begin
			next_code = ERR_CHECK;
		end else if (rx_sh[7:4] != CMD_READ_UID) begin
			next_code = ERR_CMD;
		end else begin
			next_code = ERR_NONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			last_status <= 8'h00;
		end else if (state == st_rx && rx_full) begin
			last_status <= {rx_sh[7:4], next_code};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response frame producer
	assign push = state == st_tx && tx_idx != TX_BYTES && in_ready;

	always_comb begin
		case (tx_idx)
			3'h0:    push_byte = RESP_HEADER;
			3'h1:    push_byte = unique_serial_id[31:24];
			3'h2:    push_byte = unique_serial_id[23:16];
			3'h3:    push_byte = unique_serial_id[15:8];
			3'h4:    push_byte = unique_serial_id[7:0];
			default: push_byte = tx_crc;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset || state != st_tx) begin
			tx_idx <= 3'h0;
			tx_crc <= PAY_INIT;
		end else if (push) begin
			tx_idx <= tx_idx + 3'h1;
			if (tx_idx >= TX_UID_FIRST && tx_idx < TX_CRC_IDX) begin
				tx_crc <= lftp_crc8(push_byte, PAY_POLY, tx_crc);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-entry byte buffer
	assign in_ready  = cnt != 2'h2;
	assign out_valid = cnt != 2'h0;
	assign out_ready = state == st_tx && ser_n == 4'h0;
	assign ser_load  = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wp  <= 1'h0;
			rp  <= 1'h0;
			cnt <= 2'h0;
		end else begin
			if (push) wp <= ~wp;
			if (ser_load) rp <= ~rp;
			cnt <= cnt + 2'(push) - 2'(ser_load);
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) fifo_mem[wp] <= push_byte;
	end

	////////////////////////////////////////////////////////////////////////
	// uplink serializer and bit encoder
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ser_sh <= 8'h00;
			ser_n  <= 4'h0;
		end else if (ser_load) begin
			ser_sh <= fifo_mem[rp];
			ser_n  <= BYTE_BITS;
		end else if (bit_end && state == st_tx) begin
			ser_sh <= {ser_sh[6:0], 1'h0};
			ser_n  <= ser_n - 4'h1;
		end
	end

	assign up_run = state == st_header || (state == st_rx && dps_mode) ||
		(state == st_tx && ser_n != 4'h0);
	assign bit_end = up_run && car_tick && ccnt == UP_HALF_LAST && half;

	always_comb begin
		case (state)
			st_header: next_bit = ~up_bit;
			st_tx:     next_bit = ser_sh[6];
			default:   next_bit = 1'h0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset || !up_run) begin
			ccnt <= 4'h0;
			half <= 1'h0;
		end else if (car_tick) begin
			ccnt <= ccnt + 4'h1;
			if (ccnt == UP_HALF_LAST) half <= ~half;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			up_bit <= 1'h0;
			bp_lvl <= 1'h0;
		end else begin
			if (ser_load) up_bit <= fifo_mem[rp][7];
			else if (bit_end) up_bit <= next_bit;
			else if (state == st_setup) up_bit <= 1'h1;
			else if (state == st_rx) up_bit <= 1'h0;
			if (bit_end) bp_lvl <= bp_lvl ^ up_bit;
		end
	end

	always_comb begin
		if (state == st_err) begin
			next_damp = err_lvl;
		end else if (!up_run) begin
			next_damp = 1'h0;
		end else if (cfg.uplink_biphase) begin
			next_damp = bp_lvl ^ (half & ~up_bit);
		end else begin
			next_damp = half ? ~up_bit : up_bit;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) uplink_damp <= 1'h0;
		else uplink_damp <= next_damp;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	a_reset_init: assert property (@(posedge core_clk) disable iff (1'b0)
		reset |=> state == st_wait && !uplink_damp && setup == '0)
		else $error("reset did not restore start state");
	a_field_skip: assert property (state == st_check && field_s
		|=> state == st_setup ##1 setup == '1)
		else $error("field present but no set-up");
	a_app_no_setup: assert property (app_mode |-> setup == '0)
		else $error("set-up done on application path");
	a_header_stop: assert property (state == st_header &&
		field_fall && uplink_damp |=> state == st_rx)
		else $error("header not ended by damped gap");
	a_binary_bit: assert property (pulse_end && rx_n < 4'h7 &&
		cfg.downlink_protocol_select == DLP_BINARY
		|=> rx_n == $past(rx_n) + 4'h1)
		else $error("binary pulse not one bit");
	a_quad_bits: assert property (pulse_end && rx_n < 4'h7 &&
		cfg.downlink_protocol_select == DLP_QUAD
		|=> rx_n == $past(rx_n) + 4'h2)
		else $error("quad pulse not two bits");
	a_pause_len: assert property (state == st_pause &&
		next_state != st_pause |-> tmr == 16'(PAUSE_CYCLES - 1))
		else $error("pause length wrong");
	a_err_wave: assert property (state == st_pause && tmr_end &&
		last_status[3:0] != ERR_NONE |=> state == st_err && !push)
		else $error("error did not give waveform");
	a_status_echo: assert property (state == st_rx && rx_full
		|=> last_status == {$past(rx_sh[7:4]), $past(next_code)})
		else $error("status not recorded");
	a_frame_bytes: assert property (push && tx_idx == 3'h0
		|-> push_byte == RESP_HEADER)
		else $error("frame header not first");

	c_header_end: cover property (state == st_header ##1 state == st_rx);
	c_uid_reply: cover property (state == st_tx ##1 state == st_rx);
	c_error_wave: cover property (state == st_err ##1 state == st_rx);
	c_buffer_full: cover property (cnt == 2'h2);

endmodule

// ===== lftp_bs.sv
// base station model: keyed lf field and its carrier
`timescale 1ns/100ps
module lftp_bs (
	input  wire logic core_clk,
	input  wire logic uplink_damp,
	output logic      field_on,
	output logic      field_carrier
);
////////////////////////////////////////////////////////////////////////////
	// carrier stands still low while the field is off
	initial begin
		field_on = 1'b0;
		field_carrier = 1'b0;
		#37;
		forever begin
			#400;
			field_carrier = field_on & ~field_carrier;
		end
	end
////////////////////////////////////////////////////////////////////////////
	task automatic set_field(input logic v);
		@(posedge core_clk);
		field_on <= v;
	endtask

	task automatic gap(input int n);
		set_field(1'b0);
		repeat (n) @(posedge core_clk);
		set_field(1'b1);
	endtask

	task automatic pulse(input int n);
		set_field(1'b1);
		repeat (n) @(posedge field_carrier);
		set_field(1'b0);
		repeat (40) @(posedge core_clk);
	endtask

	// request: command nibble then check nibble, msb first
	task automatic frame(input logic [7:0] b, input logic quad);
		set_field(1'b0);
		repeat (40) @(posedge core_clk);
		for (int i = 7; i >= 0; i = i - (quad ? 2 : 1)) begin
			if (quad)
				pulse(12 + 24 * int'(b[i-:2]));
			else
				pulse(b[i] ? 36 : 12);
		end
		set_field(1'b1);
	endtask

	task automatic wait_damp(input logic v);
		for (int k = 0; k < 2000 && uplink_damp !== v; k++)
			@(posedge core_clk);
	endtask

	// gap in the damped half sends a one
	task automatic damped_phase_sync_coding(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			wait_damp(1'b1);
			if (b[i])
				gap(20);
			wait_damp(1'b0);
		end
	endtask
endmodule

// ===== lf_transponder_link_frontend_bench.sv
// testbench for the lf transponder link front end
`timescale 1ns/100ps
module lf_transponder_link_frontend_bench
	import lftp_pkg::*;
();
	localparam int          PC  = 200;
	localparam int          EH  = 20;
	localparam logic [31:0] SID = 32'h5a3c96e1;

	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	logic        field_on;
	logic        field_carrier;
	logic        app_mode;
	logic        uplink_damp;
	logic [7:0]  last_status;
	lftp_cfg_t   cfg      = '0;
	lftp_setup_t setup;
	int          errors      = 0;
	int          checks_done = 0;

	always #50 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////
	lftp_frontend #(
		.PAUSE_CYCLES   (PC),
		.ERR_HALF_CYCLES(EH)
	) dut (
		.core_clk        (core_clk),
		.reset           (reset),
		.field_on        (field_on),
		.field_carrier   (field_carrier),
		.cfg             (cfg),
		.unique_serial_id(SID),
		.setup           (setup),
		.app_mode        (app_mode),
		.uplink_damp     (uplink_damp),
		.last_status     (last_status)
	);

	lftp_bs bs (
		.core_clk     (core_clk),
		.uplink_damp  (uplink_damp),
		.field_on     (field_on),
		.field_carrier(field_carrier)
	);
////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask

	// cycles until damping reaches v, bounded
	task automatic wd(input logic v, input int lim, output int n);
		n = 0;
		while (uplink_damp !== v) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > lim) begin
				chk(1'b0, "wait on damping ran out");
				complete_run;
			end
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	task automatic start(input lftp_cfg_t c, input logic f);
		@(posedge core_clk);
		cfg <= c;
		reset <= 1'b1;
		bs.set_field(f);
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		chk(setup === '0 && app_mode === 1'b0, "reset state");
	endtask

	task automatic err_wave(input logic [7:0] st);
		int n;
		wd(1'b1, 600, n);
		chk(last_status === st, "status byte");
		wd(1'b0, 40, n);
		chk(n >= 19 && n <= 21, "error high half");
		wd(1'b1, 40, n);
		chk(n >= 19 && n <= 21, "error low half");
		cyc(400);
	endtask
////////////////////////////////////////////////////////////////////////////
	task automatic t_uid;
		logic [47:0] r;
		int          n;
		start(lftp_cfg_t'{1'b0, DLP_BINARY, 1'b0, 8'h18}, 1'b1);
		cyc(1010);
		chk(setup === '1 && app_mode === 1'b0, "setup");
		bs.frame(8'h00, 1'b0);
		wd(1'b1, 600, n);
		chk(n >= 150, "pause");
		for (int i = 0; i < 48; i++) begin
			wd(~uplink_damp, 300, n);
			cyc(64);
			r = {r[46:0], ~uplink_damp};
			cyc(128);
		end
		chk(r === {8'hfe, SID, crc8(SID)}, "uid reply");
		chk(last_status === 8'h00, "uid status");
		bs.frame(8'h01, 1'b0);
		err_wave(8'h01);
	endtask

	// first reply after reset: bit 0 stays undamped, later bits decode
	task automatic t_biphase;
		logic [46:0] r;
		logic        a;
		int          n;
		start(lftp_cfg_t'{1'b0, DLP_BINARY, 1'b1, 8'h18}, 1'b1);
		cyc(1010);
		bs.frame(8'h00, 1'b0);
		wd(1'b1, 900, n);
		for (int i = 0; i < 47; i++) begin
			cyc(64);
			a = uplink_damp;
			cyc(128);
			r = {r[45:0], a === uplink_damp};
			if (i < 46)
				wd(~uplink_damp, 300, n);
		end
		chk(r === {7'h7e, SID, crc8(SID)}, "biphase reply");
	endtask

	task automatic t_quad;
		start(lftp_cfg_t'{1'b0, DLP_QUAD, 1'b0, 8'h18}, 1'b1);
		cyc(1010);
		bs.frame(8'h26, 1'b1);
		err_wave(8'h22);
		bs.frame(8'h8b, 1'b1);
		err_wave(8'h82);
	endtask

	task automatic t_dps;
		int n;
		start(lftp_cfg_t'{1'b0, DLP_DPS, 1'b0, 8'h18}, 1'b1);
		cyc(1010);
		bs.damped_phase_sync_coding(8'h13);
		for (n = 0; n < 3000 && last_status !== 8'h12; n++)
			cyc(1);
		chk(last_status === 8'h12, "damped phase status");
	endtask

	task automatic t_header;
		int n;
		start(lftp_cfg_t'{1'b1, DLP_BINARY, 1'b0, 8'h18}, 1'b1);
		wd(1'b1, 1400, n);
		wd(1'b0, 200, n);
		chk(n >= 120 && n <= 136, "header one");
		wd(1'b1, 400, n);
		chk(n >= 248 && n <= 264, "header zero");
		wd(1'b0, 400, n);
		cyc(20);
		bs.gap(30);
		wd(1'b1, 600, n);
		cyc(20);
		bs.gap(30);
		cyc(40);
		for (n = 0; n < 600 && uplink_damp === 1'b0; n++)
			cyc(1);
		chk(n == 600, "header ended");
	endtask

	task automatic t_no_field;
		start('0, 1'b0);
		cyc(1010);
		chk(app_mode === 1'b1 && setup === '0, "no field path");
	endtask
////////////////////////////////////////////////////////////////////////////
	initial begin
		t_uid;
		t_biphase;
		t_quad;
		t_dps;
		t_header;
		t_no_field;
		complete_run;
	end
endmodule
